// [design/swd_watchdog.sv]
`timescale 1ns/1ps
`include "swd_defines.svh"
module swd_watchdog #(
	parameter int unsigned SEC_CYCLES = `SWD_CLK_HZ
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic io_port_i,
	input wire swd_pkg::swd_byte_t io_wdata_i,
	output logic [7:0] io_rdata_o,
	output logic sys_reset_o,
	output logic timing_o
);
	import swd_pkg::*;

	// ----------------------------------------
	// port access and lock
	// ----------------------------------------
	swd_lock_t lock_ff;
	swd_lock_t nxt_lock;
	swd_byte_t index_ff;
	swd_byte_t nxt_index;
	swd_byte_t ldev_ff;
	swd_byte_t nxt_ldev;
	swd_byte_t act_ff;
	swd_byte_t nxt_act;
	swd_byte_t base_ff;
	swd_byte_t nxt_base;
	swd_byte_t count_ff;
	swd_byte_t nxt_count;
	swd_byte_t rdata_ff;
	swd_byte_t nxt_rdata;
	logic idx_wr;
	logic dat_wr;
	logic dat_rd;
	logic sel_wdog;
	logic restart;

	assign idx_wr = io_wr_i && io_port_i == `SWD_PORT_INDEX;
	assign dat_wr = io_wr_i && io_port_i == `SWD_PORT_DATA && lock_ff == SWD_OPEN;
	assign dat_rd = io_rd_i && io_port_i == `SWD_PORT_DATA && lock_ff == SWD_OPEN;
	assign sel_wdog = ldev_ff == `SWD_LDEV_WDOG;

	always_comb
	begin
		nxt_lock = lock_ff;
		nxt_index = index_ff;
		nxt_ldev = ldev_ff;
		nxt_act = act_ff;
		nxt_base = base_ff;
		nxt_count = count_ff;
		nxt_rdata = rdata_ff;
		restart = 1'b0;
		if (idx_wr)
		begin
			unique case (lock_ff)
				SWD_LOCKED: nxt_lock = (io_wdata_i == `SWD_UNLOCK_KEY) ? SWD_HALF : SWD_LOCKED;
				// a second key in a row opens, anything else starts over
				SWD_HALF: nxt_lock = (io_wdata_i == `SWD_UNLOCK_KEY) ? SWD_OPEN : SWD_LOCKED;
				SWD_OPEN:
				begin
					if (io_wdata_i == `SWD_LOCK_KEY)
						nxt_lock = SWD_LOCKED;
					else
						nxt_index = io_wdata_i;
				end
				default: nxt_lock = SWD_LOCKED;
			endcase
		end
		if (dat_wr)
		begin
			if (index_ff == `SWD_IDX_LDEV)
				nxt_ldev = io_wdata_i;
			else if (sel_wdog)
			begin
				unique case (index_ff)
					`SWD_IDX_ACT: nxt_act = io_wdata_i;
					`SWD_IDX_BASE: nxt_base = io_wdata_i;
					`SWD_IDX_COUNT:
					begin
						nxt_count = io_wdata_i;
						restart = 1'b1;
					end
					default: ;
				endcase
			end
		end
		if (dat_rd)
		begin
			nxt_rdata = `SWD_RST_BYTE;
			if (index_ff == `SWD_IDX_LDEV)
				nxt_rdata = ldev_ff;
			else if (sel_wdog)
			begin
				unique case (index_ff)
					`SWD_IDX_ACT: nxt_rdata = act_ff;
					`SWD_IDX_BASE: nxt_rdata = base_ff;
					`SWD_IDX_COUNT: nxt_rdata = count_ff;
					default: nxt_rdata = `SWD_RST_BYTE;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			lock_ff <= SWD_LOCKED;
			index_ff <= `SWD_RST_BYTE;
			ldev_ff <= `SWD_RST_BYTE;
			act_ff <= `SWD_RST_BYTE;
			base_ff <= `SWD_RST_BYTE;
			count_ff <= `SWD_RST_BYTE;
			rdata_ff <= `SWD_RST_BYTE;
		end
		else
		begin
			lock_ff <= nxt_lock;
			index_ff <= nxt_index;
			ldev_ff <= nxt_ldev;
			act_ff <= nxt_act;
			base_ff <= nxt_base;
			count_ff <= nxt_count;
			rdata_ff <= nxt_rdata;
		end
	end

	assign io_rdata_o = rdata_ff;

	// ----------------------------------------
	// prescaler and countdown
	// ----------------------------------------
	localparam int unsigned RST_CYC = `SWD_RESET_PULSE_CYC;
	logic [24:0] pre_ff;
	logic [24:0] nxt_pre;
	logic [5:0] min_ff;
	logic [5:0] nxt_min;
	logic [7:0] left_ff;
	logic [7:0] nxt_left;
	logic [4:0] pulse_ff;
	logic [4:0] nxt_pulse;
	logic run_ff;
	logic nxt_run;
	logic rst_out_ff;
	logic nxt_rst_out;
	logic armed;
	logic sec_tick;
	logic unit_tick;

	// zero count disables regardless of activation
	assign armed = act_ff[`SWD_ACT_BIT] && count_ff != `SWD_RST_BYTE;
	assign sec_tick = pre_ff == 25'(SEC_CYCLES - 1);
	assign unit_tick = sec_tick &&
		(!base_ff[`SWD_BASE_MIN_BIT] || min_ff == 6'(`SWD_SEC_PER_MIN - 1));

	always_comb
	begin
		nxt_pre = pre_ff;
		nxt_min = min_ff;
		nxt_left = left_ff;
		nxt_pulse = pulse_ff;
		nxt_run = armed;
		nxt_rst_out = rst_out_ff;
		// a running pulse counts down on its own, even across a disable
		if (pulse_ff != 5'h00)
			nxt_pulse = pulse_ff - 5'h01;
		// reload on arming or restart so the full period always elapses
		if (!armed || !run_ff || restart)
		begin
			nxt_pre = '0;
			nxt_min = '0;
			nxt_left = restart ? io_wdata_i : count_ff;
			if (restart)
				nxt_run = armed;
		end
		else
		begin
			nxt_pre = sec_tick ? '0 : pre_ff + 25'h0000001;
			if (sec_tick)
				nxt_min = base_ff[`SWD_BASE_MIN_BIT] && min_ff != 6'(`SWD_SEC_PER_MIN - 1)
					? min_ff + 6'h01 : 6'h00;
			if (unit_tick)
			begin
				// N units to expiry, then restart the period
				if (left_ff == 8'h01)
				begin
					nxt_left = count_ff;
					nxt_pulse = 5'(RST_CYC);
				end
				else
					nxt_left = left_ff - 8'h01;
			end
		end
		nxt_rst_out = nxt_pulse != 5'h00;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pre_ff <= '0;
			min_ff <= '0;
			left_ff <= '0;
			pulse_ff <= '0;
			run_ff <= 1'b0;
			rst_out_ff <= 1'b0;
		end
		else
		begin
			pre_ff <= nxt_pre;
			min_ff <= nxt_min;
			left_ff <= nxt_left;
			pulse_ff <= nxt_pulse;
			run_ff <= nxt_run;
			rst_out_ff <= nxt_rst_out;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------

	assign sys_reset_o = rst_out_ff;
	assign timing_o = run_ff;
endmodule

// [shared/swd_defines.svh]
`ifndef SWD_DEFINES_SVH
`define SWD_DEFINES_SVH
// Summary of operation
// - The block counts down from the preset and pulses system reset when the count hits zero.
// - Every restart reloads the counter with the preset so no reset occurs while restarts come.
// - Access uses an index port that picks a register and a data port that reads or writes it.
// - Configuration opens only after the unlock value is written twice in a row to the index port.
// - Writing 08h to index 07h selects the watchdog logical device for later accesses.
// - Writing 01h to index 30h enables the watchdog and 00h disables it at any time.
// - Index F5h picks the time base, 00h for seconds and 08h for minutes.
// - Index F6h holds an 8-bit timeout count from 0 to 255 in units of the time base.
// - A timeout value of zero disables the timeout whatever the activation state.
// - A nonzero value N times out after N units, from 1 second to 255 minutes.

// port selects
`define SWD_PORT_INDEX 1'b0
`define SWD_PORT_DATA 1'b1

// register indices
`define SWD_IDX_LDEV 8'h07
`define SWD_IDX_ACT 8'h30
`define SWD_IDX_BASE 8'hf5
`define SWD_IDX_COUNT 8'hf6

// key values
`define SWD_UNLOCK_KEY 8'h87
`define SWD_LOCK_KEY 8'haa
`define SWD_LDEV_WDOG 8'h08
`define SWD_ACT_BIT 0
`define SWD_BASE_MIN_BIT 3
`define SWD_BASE_MIN_VAL 8'h08

// reset values
`define SWD_RST_BYTE 8'h00

// timing
`define SWD_CLK_HZ 25000000
`define SWD_SEC_PER_MIN 60
`define SWD_RESET_PULSE_NS 1000
`define SWD_CLK_NS 40
`define SWD_RESET_PULSE_CYC ((`SWD_RESET_PULSE_NS + `SWD_CLK_NS - 1) / `SWD_CLK_NS)
`endif

// [shared/swd_pkg.sv]
package swd_pkg;
	typedef enum logic [1:0]
	{
		SWD_LOCKED = 2'b00,
		SWD_HALF = 2'b01,
		SWD_OPEN = 2'b10
	} swd_lock_t;
	typedef logic [7:0] swd_byte_t;
endpackage

// [testbench/swd_host_model.sv]
`timescale 1ns/1ps
module swd_host_model
(
	input wire logic clk_i,
	output logic wr_o,
	output logic rd_o,
	output logic port_o,
	output swd_pkg::swd_byte_t wdata_o
);
	import swd_pkg::*;
	initial
	begin
		{wr_o, rd_o, port_o} = 3'h0;
		wdata_o = 8'h5a;
	end
	// idle bus shows the inverse byte, never a stale one
	task automatic put(input logic p, input swd_byte_t d);
		@(negedge clk_i);
		{wr_o, port_o, wdata_o} = {1'b1, p, d};
		@(negedge clk_i);
		{wr_o, wdata_o} = {1'b0, ~d};
	endtask
	task automatic get();
		@(negedge clk_i);
		{rd_o, port_o} = 2'h3;
		@(negedge clk_i);
		rd_o = 1'b0;
		@(negedge clk_i);
	endtask
	task automatic unlock();
		put(1'b0, 8'h87);
		put(1'b0, 8'h87);
	endtask
	task automatic reg_wr(input swd_byte_t idx, input swd_byte_t d);
		put(1'b0, idx);
		put(1'b1, d);
	endtask
endmodule

// [testbench/swd_watchdog_monitor.sv]
`timescale 1ns/1ps
module swd_watchdog_monitor #(
	parameter int unsigned SEC_CYCLES = 10
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic io_port_i,
	input wire swd_pkg::swd_byte_t io_wdata_i,
	input wire logic [7:0] io_rdata_o,
	input wire logic sys_reset_o,
	input wire logic timing_o
);
	import swd_pkg::*;
	swd_byte_t idx_ff;
	swd_byte_t nxt_idx;
	// index shadow, so a restart can be told from other writes
	always_comb nxt_idx = rst_i ? 8'h00 : ((io_wr_i && !io_port_i) ? io_wdata_i : idx_ff);
	always_ff @(posedge clk_i) idx_ff <= nxt_idx;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_pulse_hold: assert property ($rose(sys_reset_o) |-> ##24 sys_reset_o)
		else $error("pulse short");
	a_pulse_end: assert property ($rose(sys_reset_o) |-> ##25 !sys_reset_o)
		else $error("pulse long");
	a_fire_cause: assert property ($rose(sys_reset_o) |-> $past(timing_o))
		else $error("reset while idle");
	a_idle_quiet: assert property (!timing_o && !sys_reset_o |=> !sys_reset_o)
		else $error("idle reset");
	a_rdata_hold: assert property (!$past(io_rd_i) |-> $stable(io_rdata_o))
		else $error("rdata moved");
	a_count_start: assert property ($rose(timing_o) |-> $past(io_wr_i, 2) || $past(io_wr_i, 3))
		else $error("start uncaused");
	a_count_stop: assert property ($fell(timing_o) |-> $past(io_wr_i, 2) || $past(io_wr_i, 3))
		else $error("stop uncaused");
	a_restart_safe: assert property (io_wr_i && io_port_i && idx_ff == 8'hf6
		&& io_wdata_i != 8'h00 |=> (!$rose(sys_reset_o)) [*8]) else $error("early reset");
	c_fire: cover property ($rose(sys_reset_o));
	c_run: cover property ($rose(timing_o));
	c_read: cover property (io_rd_i && io_port_i);
endmodule

bind swd_watchdog swd_watchdog_monitor #(.SEC_CYCLES(SEC_CYCLES)) u_mon (.clk_i, .rst_i,
	.io_wr_i, .io_rd_i, .io_port_i, .io_wdata_i, .io_rdata_o, .sys_reset_o, .timing_o);

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	import swd_pkg::*;
	localparam int SEC = 10;
	logic clk_i;
	logic rst_i;
	logic io_wr_i;
	logic io_rd_i;
	logic io_port_i;
	swd_byte_t io_wdata_i;
	logic [7:0] io_rdata_o;
	logic sys_reset_o;
	logic timing_o;
	int bad_count = 0;
	int n_checks = 0;
	int cyc;
	swd_watchdog #(.SEC_CYCLES(SEC)) uut (.clk_i, .rst_i, .io_wr_i, .io_rd_i, .io_port_i,
		.io_wdata_i, .io_rdata_o, .sys_reset_o, .timing_o);
	swd_host_model u_host (.clk_i, .wr_o(io_wr_i), .rd_o(io_rd_i), .port_o(io_port_i),
		.wdata_o(io_wdata_i));
	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input swd_byte_t idx, input swd_byte_t exp);
		u_host.put(1'b0, idx);
		u_host.get();
		cmp8(io_rdata_o, exp);
	endtask
	// span counts from the restart, a leftover pulse included
	task automatic expire(input int lo);
		for (cyc = 0; sys_reset_o === 1'b1; cyc++) @(negedge clk_i);
		for (; sys_reset_o !== 1'b1 && cyc < lo + 8; cyc++) @(negedge clk_i);
		cmp8({7'h0, cyc >= lo - 3 && cyc <= lo + 3}, 8'h01);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		rst_i = 1'b1;
		repeat (12) @(negedge clk_i);
		rst_i = 1'b0;
		cmp8(io_rdata_o, 8'h00);
		cmp8({6'h0, timing_o, sys_reset_o}, 8'h00);
		u_host.unlock();
		u_host.reg_wr(8'hf6, 8'h44);
		u_host.reg_wr(8'h07, 8'h08);
		rd_chk(8'h07, 8'h08);
		rd_chk(8'hf6, 8'h00);
		u_host.reg_wr(8'hf6, 8'h03);
		u_host.put(1'b0, 8'haa);
		u_host.put(1'b1, 8'h22);
		u_host.put(1'b0, 8'h87);
		u_host.put(1'b0, 8'hf6);
		u_host.put(1'b1, 8'h33);
		u_host.unlock();
		rd_chk(8'hf6, 8'h03);
		u_host.reg_wr(8'hf5, 8'h08);
		rd_chk(8'hf5, 8'h08);
		u_host.reg_wr(8'hf5, 8'h00);
		u_host.reg_wr(8'h30, 8'h01);
		rd_chk(8'h30, 8'h01);
		cmp8({7'h0, timing_o}, 8'h01);
		// restart period kept well inside the three-unit timeout
		repeat (4)
		begin
			u_host.reg_wr(8'hf6, 8'h03);
			repeat (18) @(negedge clk_i);
			cmp8({7'h0, sys_reset_o}, 8'h00);
		end
		u_host.reg_wr(8'hf6, 8'h03);
		expire(3 * SEC);
		u_host.reg_wr(8'hf5, 8'h08);
		u_host.reg_wr(8'hf6, 8'h01);
		expire(60 * SEC);
		u_host.reg_wr(8'hf5, 8'h00);
		u_host.reg_wr(8'hf6, 8'hff);
		rd_chk(8'hf6, 8'hff);
		u_host.reg_wr(8'hf6, 8'h00);
		repeat (100) @(negedge clk_i);
		cmp8({6'h0, timing_o, sys_reset_o}, 8'h00);
		u_host.reg_wr(8'hf6, 8'h05);
		repeat (2) @(negedge clk_i);
		cmp8({7'h0, timing_o}, 8'h01);
		u_host.reg_wr(8'h30, 8'h00);
		repeat (60) @(negedge clk_i);
		cmp8({6'h0, timing_o, sys_reset_o}, 8'h00);
		rd_chk(8'h20, 8'h00);
		// watchdog registers hide once another logical device is picked
		u_host.reg_wr(8'h07, 8'h01);
		rd_chk(8'hf6, 8'h00);
		rd_chk(8'h07, 8'h01);
		// a locked data read leaves the last byte in place
		u_host.put(1'b0, 8'haa);
		u_host.get();
		cmp8(io_rdata_o, 8'h01);
		give_verdict();
	end
	initial
	begin
		#400000;
		bad_count++;
		give_verdict();
	end
endmodule
